/* fscs_pkg.sv */
// shared constants and carrier types for the fractional sample clock block
package fscs_pkg;

  // -------------------------------------------------------------------------
  // register map (byte addresses)
  // -------------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_PER_INT   = 8'h04;
  localparam logic [7:0] OFS_PER_FRAC  = 8'h08;
  localparam logic [7:0] OFS_STATUS    = 8'h0C;
  localparam logic [7:0] OFS_STAMP     = 8'h10;
  localparam logic [7:0] OFS_FRAC_ACC  = 8'h14;

  // -------------------------------------------------------------------------
  // fields and reset values
  // -------------------------------------------------------------------------
  localparam int CTRL_ASYM_EN     = 0;
  localparam int CTRL_RESTART     = 1;
  localparam int ST_IN_SERVICE    = 8;
  localparam int ST_FAIL          = 9;
  localparam int ST_LOCKED        = 10;
  localparam int ST_ASYM          = 11;
  localparam int ST_TARGET        = 12;
  localparam int ST_STARTUP       = 13;
  localparam int ST_STALE         = 14;
  localparam logic [15:0] NOM_INT  = 16'h0A2C;   // 10 MHz / (60 Hz * 64)
  localparam logic [15:0] NOM_FRAC = 16'h2AAB;
  localparam logic [1:0]  SAMPLES_PER_RELOAD_M1 = 2'h3;
  localparam logic [3:0]  LOST_RUN_MAX = 4'h8;   // eight messages = two cycles
  localparam logic [15:0] LOCK_THR     = 16'h0040;
  localparam logic [15:0] ASYM_THR_US  = 16'h05DC; // 1.5 ms

  // -------------------------------------------------------------------------
  // timing
  // -------------------------------------------------------------------------
  localparam int CLK_KHZ     = 10000;
  localparam int STALE_US    = 66000;
  localparam int STALE_CYC   = STALE_US * CLK_KHZ / 1000;
  localparam int WDOG_US     = 66000;
  localparam int WDOG_CYC    = WDOG_US * CLK_KHZ / 1000;

  // -------------------------------------------------------------------------
  // message carriers
  // -------------------------------------------------------------------------
  typedef struct packed {
    logic       startup;
    logic [3:0] seq;
    logic [7:0] stamp;
  } fscs_rx_s;

  typedef struct packed {
    logic       startup;
    logic [3:0] seq;
    logic [7:0] stamp;
    logic [7:0] echo_remote;
    logic [7:0] echo_rx;
  } fscs_tx_s;

endpackage

/* fscs_top.sv */
// fractional sample clock, message stamping and channel supervision
//
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/1ps
module fscs_top #(
  parameter int STALE_CYC = fscs_pkg::STALE_CYC,
  parameter int WDOG_CYC  = fscs_pkg::WDOG_CYC
) (
  input  wire logic              CLK,
  input  wire logic              RESET,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [7:0]        PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  output logic [31:0]            PRDATA,
  input  wire logic              RX_VALID,
  input  wire fscs_pkg::fscs_rx_s RX_MSG,
  input  wire logic              TX_REQ,
  output logic                   TX_VALID,
  output fscs_pkg::fscs_tx_s     TX_MSG,
  input  wire logic              LOCAL_SET_READY,
  input  wire logic [15:0]       UNCERTAINTY,
  input  wire logic [15:0]       ASYM_US,
  output logic                   SAMPLE,
  output logic                   DIFF_RUN,
  output logic [3:0]             DIFF_SEQ,
  output logic                   PROT_ENABLE,
  output logic                   ASYM_EVENT
);

  logic        wr_en;
  logic        rd_en;
  logic        hit;
  logic [15:0] per_int_q;
  logic [15:0] per_frac_q;
  logic        asym_en_q;
  logic [15:0] cnt_q;
  logic [15:0] reload_q;
  logic [1:0]  grp_q;
  logic [15:0] facc_q;
  logic [16:0] fsum;
  logic        grp_end;
  logic [7:0]  ts_q;
  logic [3:0]  seq;
  logic [31:0] wd_q;
  logic        in_svc_q;
  logic        fail_q;
  logic        stale_q;
  logic        have_last_q;
  logic [3:0]  last_seq_q;
  logic [3:0]  gap;
  logic        gap_q;
  logic [3:0]  miss_run_q;
  logic [7:0]  echo_rem_q;
  logic [7:0]  echo_rx_q;
  logic        locked;
  logic        asym_q;
  logic        target_q;
  logic [15:0] avail_q;
  logic        startup_form;
  logic        rx_data;
  logic        restart;

  // -------------------------------------------------------------------------
  // apb slave
  // -------------------------------------------------------------------------

  // zero-wait slave, unmapped offsets answer with an error
  always_comb begin
    hit = (PADDR == fscs_pkg::OFS_CTRL) || (PADDR == fscs_pkg::OFS_PER_INT)
       || (PADDR == fscs_pkg::OFS_PER_FRAC) || (PADDR == fscs_pkg::OFS_STATUS)
       || (PADDR == fscs_pkg::OFS_STAMP) || (PADDR == fscs_pkg::OFS_FRAC_ACC);
    PREADY  = 1'b1;
    PSLVERR = PSEL && PENABLE && !hit;
    wr_en   = PSEL && PENABLE && PWRITE && hit;
    rd_en   = PSEL && !PENABLE && !PWRITE;
  end

  assign restart = wr_en && (PADDR == fscs_pkg::OFS_CTRL) && PWDATA[fscs_pkg::CTRL_RESTART];

  // period registers start at nominal and take writes at once, the counter picks them up at the next group end
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      per_int_q  <= fscs_pkg::NOM_INT;
      per_frac_q <= fscs_pkg::NOM_FRAC;
      asym_en_q  <= 1'b0;
    end else if (wr_en) begin
      if (PADDR == fscs_pkg::OFS_PER_INT) begin
        per_int_q <= PWDATA[15:0];
      end else if (PADDR == fscs_pkg::OFS_PER_FRAC) begin
        per_frac_q <= PWDATA[15:0];
      end else if (PADDR == fscs_pkg::OFS_CTRL) begin
        asym_en_q <= PWDATA[fscs_pkg::CTRL_ASYM_EN];
      end
    end
  end

  // read data registered in the setup cycle, stamp read has no side effect
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      PRDATA <= 32'h0000_0000;
    end else if (rd_en) begin
      if (PADDR == fscs_pkg::OFS_CTRL) begin
        PRDATA <= {30'h0000_0000, 1'b0, asym_en_q};
      end else if (PADDR == fscs_pkg::OFS_PER_INT) begin
        PRDATA <= {16'h0000, per_int_q};
      end else if (PADDR == fscs_pkg::OFS_PER_FRAC) begin
        PRDATA <= {16'h0000, per_frac_q};
      end else if (PADDR == fscs_pkg::OFS_STATUS) begin
        PRDATA <= {17'h0000, stale_q, startup_form, target_q, asym_q, locked,
                   fail_q, in_svc_q, 4'h0, miss_run_q};
      end else if (PADDR == fscs_pkg::OFS_STAMP) begin
        PRDATA <= {20'h0_0000, seq, ts_q};
      end else if (PADDR == fscs_pkg::OFS_FRAC_ACC) begin
        PRDATA <= {16'h0000, facc_q};
      end else begin
        PRDATA <= 32'h0000_0000;
      end
    end
  end

  // -------------------------------------------------------------------------
  // fractional sample clock
  // -------------------------------------------------------------------------

  // count reaches one at the last cycle of a sample period
  assign SAMPLE  = (cnt_q == 16'h0001);
  assign grp_end = SAMPLE && (grp_q == fscs_pkg::SAMPLES_PER_RELOAD_M1);
  assign fsum    = {1'b0, facc_q} + {1'b0, per_frac_q};

  // down-counter, reload value latched only at group boundaries
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      cnt_q    <= fscs_pkg::NOM_INT;
      reload_q <= fscs_pkg::NOM_INT;
      grp_q    <= 2'h0;
    end else if (SAMPLE) begin
      grp_q <= grp_q + 2'h1;
      if (grp_end) begin
        reload_q <= per_int_q + {15'h0000, fsum[16]};
        cnt_q    <= per_int_q + {15'h0000, fsum[16]};
      end else begin
        cnt_q <= reload_q;
      end
    end else begin
      cnt_q <= cnt_q - 16'h0001;
    end
  end

  // running fraction, only ever added to
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      facc_q <= 16'h0000;
    end else if (grp_end) begin
      facc_q <= fsum[15:0];
    end
  end

  // stamp counter wraps every 256 samples, four cycles from reset alignment
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ts_q <= 8'h00;
    end else if (SAMPLE) begin
      ts_q <= ts_q + 8'h01;
    end
  end

  assign seq = ts_q[7:4];

  // -------------------------------------------------------------------------
  // channel supervision
  // -------------------------------------------------------------------------

  assign rx_data = RX_VALID && !RX_MSG.startup;
  assign gap     = RX_MSG.seq - last_seq_q - 4'h1;

  // interval watchdog since the last message of any form
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      wd_q    <= 32'h0000_0000;
      stale_q <= 1'b1;
    end else if (RX_VALID) begin
      wd_q    <= 32'h0000_0000;
      stale_q <= 1'b0;
    end else begin
      if (wd_q < 32'hFFFF_FFFF) begin
        wd_q <= wd_q + 32'h0000_0001;
      end
      if (wd_q >= 32'(STALE_CYC)) begin
        stale_q <= 1'b1;
      end
    end
  end

  // service state, failure and lost-message tracking
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      in_svc_q    <= 1'b0;
      fail_q      <= 1'b0;
      have_last_q <= 1'b0;
      last_seq_q  <= 4'h0;
      gap_q       <= 1'b0;
      miss_run_q  <= 4'h0;
    end else if (restart) begin
      in_svc_q    <= 1'b0;
      fail_q      <= 1'b0;
      have_last_q <= 1'b0;
      gap_q       <= 1'b0;
      miss_run_q  <= 4'h0;
    end else if (RX_VALID) begin
      in_svc_q <= 1'b1;
      fail_q   <= 1'b0;
      if (rx_data) begin
        have_last_q <= 1'b1;
        last_seq_q  <= RX_MSG.seq;
        if (have_last_q && gap != 4'h0) begin
          gap_q      <= 1'b1;
          miss_run_q <= gap;
          if (gap >= fscs_pkg::LOST_RUN_MAX) begin
            fail_q   <= 1'b1;
            in_svc_q <= 1'b0;
          end
        end else begin
          gap_q      <= 1'b0;
          miss_run_q <= 4'h0;
        end
      end
    end else if (wd_q >= 32'(WDOG_CYC)) begin
      fail_q      <= in_svc_q | fail_q;
      in_svc_q    <= 1'b0;
      have_last_q <= 1'b0;
    end
  end

  // stored stamps for the next outgoing message
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      echo_rem_q <= 8'h00;
      echo_rx_q  <= 8'h00;
    end else if (RX_VALID) begin
      echo_rem_q <= RX_MSG.stamp;
      echo_rx_q  <= ts_q;
    end
  end

  assign startup_form = !in_svc_q || fail_q || stale_q;

  // outgoing message, registered on request
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      TX_VALID <= 1'b0;
      TX_MSG   <= '0;
    end else begin
      TX_VALID <= TX_REQ;
      if (TX_REQ) begin
        TX_MSG.startup     <= startup_form;
        TX_MSG.seq         <= seq;
        TX_MSG.stamp       <= ts_q;
        TX_MSG.echo_remote <= startup_form ? 8'h00 : echo_rem_q;
        TX_MSG.echo_rx     <= startup_form ? 8'h00 : echo_rx_q;
      end
    end
  end

  // -------------------------------------------------------------------------
  // lock, matching and asymmetry
  // -------------------------------------------------------------------------

  assign locked      = in_svc_q && !fail_q && (UNCERTAINTY < fscs_pkg::LOCK_THR);
  assign PROT_ENABLE = locked && !gap_q;

  // local sets available per sequence number, set wins over consumption
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      avail_q <= 16'h0000;
    end else begin
      for (int i = 0; i < 16; i++) begin
        if (LOCAL_SET_READY && seq == 4'(i)) begin
          avail_q[i] <= 1'b1;
        end else if (rx_data && RX_MSG.seq == 4'(i)) begin
          avail_q[i] <= 1'b0;
        end
      end
    end
  end

  // run the differential on a matched pair only, never on start-up form
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      DIFF_RUN <= 1'b0;
      DIFF_SEQ <= 4'h0;
    end else begin
      DIFF_RUN <= rx_data && avail_q[RX_MSG.seq] && locked;
      DIFF_SEQ <= RX_MSG.seq;
    end
  end

  // asymmetry flag, event pulse and sticky target
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      asym_q     <= 1'b0;
      target_q   <= 1'b0;
      ASYM_EVENT <= 1'b0;
    end else begin
      asym_q     <= ASYM_US > fscs_pkg::ASYM_THR_US;
      ASYM_EVENT <= asym_en_q && !asym_q && (ASYM_US > fscs_pkg::ASYM_THR_US);
      if (asym_en_q && asym_q) begin
        target_q <= 1'b1;
      end else if (wr_en && PADDR == fscs_pkg::OFS_STATUS
                   && PWDATA[fscs_pkg::ST_TARGET]) begin
        target_q <= 1'b0;
      end
    end
  end

  // -------------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------------

  AST_SAMPLE_RELOAD: assert property (@(posedge CLK) disable iff (RESET)
    SAMPLE && !grp_end |=> cnt_q == reload_q)
    else $error("counter not reloaded after sample");

  AST_GROUP_RELOAD: assert property (@(posedge CLK) disable iff (RESET)
    grp_end |=> reload_q == $past(per_int_q) + {15'h0000, $past(fsum[16])})
    else $error("group reload value wrong");

  AST_FRAC_HOLD: assert property (@(posedge CLK) disable iff (RESET)
    !grp_end |=> $stable(facc_q))
    else $error("fraction accumulator changed off reload");

  AST_FRAC_ADD: assert property (@(posedge CLK) disable iff (RESET)
    grp_end |=> facc_q == 16'($past(facc_q) + $past(per_frac_q)))
    else $error("fraction not accumulated");

  AST_STAMP_STEP: assert property (@(posedge CLK) disable iff (RESET)
    SAMPLE |=> ts_q == 8'($past(ts_q) + 8'h01))
    else $error("stamp did not advance on sample");

  AST_SEQ_BITS: assert property (@(posedge CLK) disable iff (RESET)
    TX_REQ |=> TX_VALID && TX_MSG.seq == $past(ts_q[7:4]))
    else $error("sequence not top stamp bits");

  AST_STARTUP_FORM: assert property (@(posedge CLK) disable iff (RESET)
    TX_REQ && !in_svc_q |=> TX_MSG.startup && TX_MSG.echo_rx == 8'h00)
    else $error("start-up form missing while out of service");

  AST_WDOG_FAIL: assert property (@(posedge CLK) disable iff (RESET)
    in_svc_q && !RX_VALID && !restart && wd_q >= 32'(WDOG_CYC) |=> fail_q && !in_svc_q)
    else $error("watchdog expiry did not fail channel");

  AST_GAP_SUSPEND: assert property (@(posedge CLK) disable iff (RESET)
    rx_data && have_last_q && gap != 4'h0 && !restart |=> !PROT_ENABLE)
    else $error("protection not suspended on gap");

  AST_MATCH_ONLY: assert property (@(posedge CLK) disable iff (RESET)
    DIFF_RUN |-> $past(rx_data) && $past(avail_q[RX_MSG.seq]))
    else $error("differential ran without matched set");

  AST_ASYM_FLAG: assert property (@(posedge CLK) disable iff (RESET)
    ASYM_US > fscs_pkg::ASYM_THR_US |=> asym_q)
    else $error("asymmetry flag not set");

endmodule

/* fscs_peer.sv */
// remote peer terminal model that sends stamped messages into the block
`timescale 1ns/1ps
module fscs_peer (
  input  wire logic          clk,
  output logic               rx_valid,
  output fscs_pkg::fscs_rx_s rx_msg
);
  fscs_pkg::fscs_rx_s last_q;

  // idle line until the first message
  initial begin
    rx_valid = 1'b0;
    rx_msg   = '0;
    last_q   = '0;
  end

  // one message after dly idle cycles; line shows inverse once released
  task automatic send(input logic su, input logic [3:0] sq, input logic [7:0] st,
                      input int dly);
    repeat (dly) @(posedge clk);
    @(posedge clk);
    last_q = {su, sq, st};
    rx_valid <= 1'b1;
    rx_msg   <= last_q;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_msg   <= ~last_q;
  endtask
endmodule

/* fscs_top_tb.sv */
// self-checking bench for the fractional sample clock block
`timescale 1ns/1ps
module fscs_top_tb;
  logic               clk, reset, psel, penable, pwrite, pready, pslverr;
  logic               rx_valid, tx_req, tx_valid, set_rdy, sample, diff_run, prot_en, asym_ev;
  logic [7:0]         paddr, ts, rxts;
  logic [3:0]         diff_seq, p;
  logic [15:0]        uncert, asym_us;
  logic [31:0]        pwdata, prdata, r, f0, f1, f2, seed;
  fscs_pkg::fscs_rx_s rx_msg;
  fscs_pkg::fscs_tx_s tx_msg;
  int                 failures, checks, smp_n, cyc, last_cyc, sum, bad;
  int                 iv_q[$];
  logic [64:0]        apb_q[$];
  logic [63:0]        tx_q[$], dif_q[$], asy_q[$];

  fscs_top #(.STALE_CYC(3000), .WDOG_CYC(2000)) dut (
    .CLK(clk), .RESET(reset), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PSLVERR(pslverr), .PRDATA(prdata),
    .RX_VALID(rx_valid), .RX_MSG(rx_msg), .TX_REQ(tx_req), .TX_VALID(tx_valid),
    .TX_MSG(tx_msg), .LOCAL_SET_READY(set_rdy), .UNCERTAINTY(uncert), .ASYM_US(asym_us),
    .SAMPLE(sample), .DIFF_RUN(diff_run), .DIFF_SEQ(diff_seq), .PROT_ENABLE(prot_en),
    .ASYM_EVENT(asym_ev));

  fscs_peer peer (.clk(clk), .rx_valid(rx_valid), .rx_msg(rx_msg));

  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ---------------------------------------------------------------------------
  // helper tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // one apb transfer, held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                    input logic err);
    logic [31:0] q;
    apb_q.push_back({err, m, e});
    apb(1'b0, a, 32'h0000_0000, q);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask

  // wait until just after a sample edge and note the stamp
  task automatic sync();
    @(negedge clk);
    while (sample !== 1'b1) @(negedge clk);
    @(negedge clk);
    ts = smp_n[7:0];
  endtask

  task automatic tx(input logic su, input logic [7:0] e_rem, input logic [7:0] e_rx);
    tx_q.push_back({su, ts[7:4], ts, e_rem, e_rx});
    @(posedge clk);
    tx_req <= 1'b1;
    @(posedge clk);
    tx_req <= 1'b0;
  endtask

  // ---------------------------------------------------------------------------
  // output monitor: sample timing and queued results
  // ---------------------------------------------------------------------------
  always @(posedge clk) begin
    logic [64:0] e;
    if (reset === 1'b0) begin
      cyc = cyc + 1;
      if (sample === 1'b1) begin
        if (smp_n > 0) iv_q.push_back(cyc - last_cyc);
        last_cyc = cyc;
        smp_n    = smp_n + 1;
      end
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0
          && apb_q.size() > 0) begin
        e = apb_q.pop_front();
        chk({pslverr, prdata & e[63:32]}, {e[64], e[31:0]});
      end
      // an empty queue yields a value that no output can match
      if (tx_valid === 1'b1) begin
        e = tx_q.size() > 0 ? tx_q.pop_front() : 65'h0_0000_0001_0000_0000;
        chk(tx_msg, e[63:0]);
      end
      if (diff_run === 1'b1) begin
        e = dif_q.size() > 0 ? dif_q.pop_front() : 65'h0_0000_0001_0000_0000;
        chk(diff_seq, e[63:0]);
      end
      if (asym_ev === 1'b1) begin
        e = asy_q.size() > 0 ? asy_q.pop_front() : 65'h0_0000_0000_0000_0000;
        chk(64'h0000_0000_0000_0001, e[63:0]);
      end
    end
  end

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    seed = 32'h0000_2AE4;
    {reset, psel, penable, pwrite, tx_req, set_rdy} = 6'h20;
    {paddr, pwdata, uncert, asym_us} = '0;
    uncert = 16'hFFFF;
    {failures, checks, smp_n, cyc, last_cyc} = '0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    rd(fscs_pkg::OFS_PER_INT, 32'hFFFF_FFFF, 32'h0000_0A2C, 1'b0);
    rd(fscs_pkg::OFS_PER_FRAC, 32'hFFFF_FFFF, 32'h0000_2AAB, 1'b0);
    rd(fscs_pkg::OFS_CTRL, 32'hFFFF_FFFF, 32'h0000_0000, 1'b0);
    rd(fscs_pkg::OFS_FRAC_ACC, 32'hFFFF_FFFF, 32'h0000_0000, 1'b0);
    rd(fscs_pkg::OFS_STATUS, 32'h0000_0700, 32'h0000_0000, 1'b0);
    rd(8'h18, 32'h0000_0000, 32'h0000_0000, 1'b1);
    wr(fscs_pkg::OFS_PER_INT, 32'h0000_0010);
    wr(fscs_pkg::OFS_PER_FRAC, 32'h0000_8000);
    while (smp_n < 2) @(negedge clk);
    chk(iv_q[0], 32'h0000_0A2C);
    // fraction 0x8000 lengthens every other group of four by one
    while (smp_n < 12) @(negedge clk);
    iv_q.delete();
    while (iv_q.size() < 32) @(negedge clk);
    sum = 0;
    bad = 0;
    for (int i = 0; i < 32; i++) begin
      sum += iv_q[i];
      if (iv_q[i] != 32'h0000_0010 && iv_q[i] != 32'h0000_0011) bad++;
    end
    chk(bad, 32'h0000_0000);
    chk(sum, 32'h0000_0210);
    // accumulator gains one fraction per group and survives a period write
    do sync(); while (ts[1:0] != 2'h1);
    apb(1'b0, fscs_pkg::OFS_FRAC_ACC, 32'h0000_0000, f0);
    repeat (4) sync();
    apb(1'b0, fscs_pkg::OFS_FRAC_ACC, 32'h0000_0000, f1);
    chk(f1, (f0 + 32'h0000_8000) & 32'h0000_FFFF);
    wr(fscs_pkg::OFS_PER_FRAC, 32'h0000_4000);
    apb(1'b0, fscs_pkg::OFS_FRAC_ACC, 32'h0000_0000, f2);
    chk(f2, f1);
    while (smp_n < 258) @(negedge clk);
    sync();
    rd(fscs_pkg::OFS_STAMP, 32'h0000_0FFF, {20'h0_0000, ts[7:4], ts}, 1'b0);
    // start-up exchange, then data form with echoed stamps
    @(posedge clk);
    uncert <= 16'h003F;
    sync();
    tx(1'b1, 8'h00, 8'h00);
    r = $random(seed);
    sync();
    peer.send(1'b1, r[11:8], r[7:0], 0);
    rxts = ts;
    rd(fscs_pkg::OFS_STATUS, 32'h0000_0100, 32'h0000_0100, 1'b0);
    sync();
    tx(1'b0, r[7:0], rxts);
    // matched set, then a gap of two and recovery
    do sync(); while (ts[3:0] != 4'h1);
    p = ts[7:4] - 4'h1;
    peer.send(1'b0, p, r[15:8], r[1:0]);
    @(posedge clk);
    set_rdy <= 1'b1;
    @(posedge clk);
    set_rdy <= 1'b0;
    dif_q.push_back(ts[7:4]);
    peer.send(1'b0, p + 4'h1, r[23:16], 0);
    @(negedge clk);
    chk(prot_en, 1'b1);
    peer.send(1'b0, p + 4'h4, r[31:24], r[3:2]);
    @(negedge clk);
    chk(prot_en, 1'b0);
    rd(fscs_pkg::OFS_STATUS, 32'h0000_000F, 32'h0000_0002, 1'b0);
    peer.send(1'b0, p + 4'h5, r[7:0], 0);
    @(negedge clk);
    chk(prot_en, 1'b1);
    @(posedge clk);
    uncert <= 16'h0040;
    @(negedge clk);
    chk(prot_en, 1'b0);
    @(posedge clk);
    uncert <= 16'h003F;
    // asymmetry above 1.5 ms raises event and target only when enabled
    wr(fscs_pkg::OFS_CTRL, 32'h0000_0001);
    asym_us <= 16'h05DC;
    repeat (4) @(posedge clk);
    asy_q.push_back(64'h0000_0000_0000_0001);
    asym_us <= 16'h05DD;
    repeat (4) @(posedge clk);
    rd(fscs_pkg::OFS_STATUS, 32'h0000_1800, 32'h0000_1800, 1'b0);
    asym_us <= 16'h0000;
    wr(fscs_pkg::OFS_CTRL, 32'h0000_0000);
    asym_us <= 16'h05DD;
    repeat (4) @(posedge clk);
    asym_us <= 16'h0000;
    // a run of seven lost is tolerated, eight declares failure
    peer.send(1'b0, p + 4'hD, r[7:0], 0);
    rd(fscs_pkg::OFS_STATUS, 32'h0000_0200, 32'h0000_0000, 1'b0);
    peer.send(1'b0, p + 4'h6, r[7:0], 0);
    rd(fscs_pkg::OFS_STATUS, 32'h0000_0200, 32'h0000_0200, 1'b0);
    sync();
    tx(1'b1, 8'h00, 8'h00);
    peer.send(1'b0, p + 4'h7, r[7:0], 0);
    rd(fscs_pkg::OFS_STATUS, 32'h0000_0300, 32'h0000_0100, 1'b0);
    // silence beyond the watchdog limit
    repeat (2100) @(posedge clk);
    rd(fscs_pkg::OFS_STATUS, 32'h0000_0200, 32'h0000_0200, 1'b0);
    // restart clears service and failure, long silence marks stamps stale
    wr(fscs_pkg::OFS_CTRL, 32'h0000_0002);
    rd(fscs_pkg::OFS_STATUS, 32'h0000_0300, 32'h0000_0000, 1'b0);
    repeat (1000) @(posedge clk);
    rd(fscs_pkg::OFS_STATUS, 32'h0000_6000, 32'h0000_6000, 1'b0);
    // target clears by writing one while no asymmetry is seen
    wr(fscs_pkg::OFS_STATUS, 32'h0000_1000);
    rd(fscs_pkg::OFS_STATUS, 32'h0000_1000, 32'h0000_0000, 1'b0);
    repeat (4) @(posedge clk);
    chk(tx_q.size() + dif_q.size() + asy_q.size() + apb_q.size(), 32'h0000_0000);
    end_of_test();
  end

  // hang guard
  initial begin
    #(100 * 40000);
    failures++;
    end_of_test();
  end
endmodule
